// ### pmf_pkg.sv
// Package: register map, codes and reset values of the loop mode block
package pmf_pkg;

	// ********************************
	// Widths and counts
	// ********************************
	localparam int DW    = 16;
	localparam int AW    = 8;
	localparam int N_IN  = 7;
	localparam int N_OUT = 3;
	localparam int N_EV  = 4;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [AW-1:0] A_MODE   = 8'h00;
	localparam logic [AW-1:0] A_SETPT  = 8'h04;
	localparam logic [AW-1:0] A_UPLIM  = 8'h08;
	localparam logic [AW-1:0] A_LOLIM  = 8'h0C;
	localparam logic [AW-1:0] A_SWFRQ  = 8'h10;
	localparam logic [AW-1:0] A_NETIN  = 8'h14;
	localparam logic [AW-1:0] A_IRQST  = 8'h18;
	localparam logic [AW-1:0] A_IRQMSK = 8'h1C;
	localparam logic [AW-1:0] A_STATE  = 8'h20;
	localparam logic [AW-1:0] A_INFN0  = 8'h40;
	localparam logic [AW-1:0] A_OUTFN0 = 8'h60;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [7:0]    RST_MODE  = 8'h00;
	localparam logic [DW-1:0] PARAM_OFF = 16'h270F;
	localparam logic [7:0]    RST_INFN  = 8'h00;
	localparam logic [7:0]    RST_OUTFN = 8'h00;

	// Switchover limit, 400.0 Hz in 0.1 Hz steps
	localparam logic [DW-1:0] SWFRQ_MAX = 16'h0FA0;

	// ********************************
	// Mode and function codes
	// ********************************
	localparam logic [7:0] MODE_NONE  = 8'h00;
	localparam logic [7:0] MODE_T_REV = 8'h14;
	localparam logic [7:0] MODE_T_FWD = 8'h15;
	localparam logic [7:0] MODE_D_REV = 8'h32;
	localparam logic [7:0] MODE_D_FWD = 8'h33;
	localparam logic [7:0] MODE_B_REV = 8'h3C;
	localparam logic [7:0] MODE_B_FWD = 8'h3D;
	localparam logic [7:0] IN_SEL     = 8'h0E;
	localparam logic [7:0] OUT_LO     = 8'h0E;
	localparam logic [7:0] OUT_UP     = 8'h0F;
	localparam logic [7:0] OUT_DIR    = 8'h10;
	localparam logic [7:0] OUT_ACT    = 8'h2F;
	localparam logic [7:0] OUT_INV    = 8'h64;

	// ********************************
	// Event and state bit positions
	// ********************************
	localparam int EV_LOOP = 0;
	localparam int EV_SW   = 1;
	localparam int EV_UP   = 2;
	localparam int EV_LO   = 3;

	typedef enum logic [2:0] {
		SW_STOP   = 3'b001,
		SW_NORMAL = 3'b010,
		SW_LOOP   = 3'b100
	} pmf_sw_t;

endpackage

// ### pmf_flag_if.sv
// Interface: the four loop flags handed to the output mappers
`timescale 1ns/100ps
interface pmf_flag_if;
	logic up;
	logic lo;
	logic dir;
	logic act;
	modport drv (output up, lo, dir, act);
	modport rcv (input up, lo, dir, act);
endinterface

// ### pmf_out_map.sv
// Output terminal mapper: function code to terminal level
`timescale 1ns/100ps
module pmf_out_map
	import pmf_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Selection
	input  wire logic [7:0] code,
	pmf_flag_if.rcv         flags,
	// Terminal
	output logic            term_reg
);

	wire       inv  = code >= OUT_INV;
	wire [7:0] base = inv ? code - OUT_INV : code;
	wire       hit  = (base == OUT_UP) | (base == OUT_LO) |
		(base == OUT_DIR) | (base == OUT_ACT);
	wire       lvl  = (base == OUT_UP & flags.up) |
		(base == OUT_LO & flags.lo) |
		(base == OUT_DIR & flags.dir) |
		(base == OUT_ACT & flags.act);
	// Unused codes stay low even when inverted
	wire       term_next = hit & (lvl ^ inv);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			term_reg <= 1'b0;
		end else begin
			term_reg <= term_next;
		end
	end

	inv_act_a: assert property (@(posedge clk) disable iff (rst)
		(code == OUT_INV + OUT_ACT) |=> term_reg == !$past(flags.act))
		else $error("inverted loop flag wrong");

endmodule

// ### pmf_top.sv
// Loop mode select, source select, flags and switchover sequencing
`timescale 1ns/100ps
module pmf_top
	import pmf_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Register port
	input  wire logic [AW-1:0]    reg_addr,
	input  wire logic [DW-1:0]    reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [DW-1:0]    reg_rdata,
	// Drive state
	input  wire logic [N_IN-1:0]  in_term,
	input  wire logic             drive_run,
	input  wire logic             drive_fwd,
	input  wire logic             multi_speed,
	input  wire logic             jog_cmd,
	input  wire logic [DW-1:0]    out_freq,
	// Analog terminals, 0.1 % steps
	input  wire logic [DW-1:0]    term2_value,
	input  wire logic [DW-1:0]    term4_value,
	// Fieldbus values
	input  wire logic [DW-1:0]    fb_deviation,
	input  wire logic [DW-1:0]    fb_set_value,
	input  wire logic [DW-1:0]    fb_meas_value,
	// Regulator side
	output logic                  loop_active_flag,
	output logic      [DW-1:0]    sp_out,
	output logic      [DW-1:0]    pv_out,
	output logic      [DW-1:0]    dev_out,
	output logic                  dev_direct,
	// Output terminals and interrupt
	output logic      [N_OUT-1:0] out_term,
	output logic                  irq
);

	// ********************************
	// Registers
	// ********************************
	logic [7:0]      mode_reg;
	logic [DW-1:0]   setpt_reg;
	logic [DW-1:0]   uplim_reg;
	logic [DW-1:0]   lolim_reg;
	logic [DW-1:0]   swfrq_reg;
	logic [N_IN-1:0] netin_reg;
	logic [N_EV-1:0] irq_st_reg;
	logic [N_EV-1:0] irq_msk_reg;
	logic [7:0]      in_fn_reg [N_IN];
	logic [7:0]      out_fn_reg [N_OUT];
	logic            up_reg;
	logic            lo_reg;
	logic            dir_reg;
	pmf_sw_t         sw_reg;
	pmf_sw_t         sw_next;
	logic [N_EV-1:0] ev;
	logic [N_IN-1:0] sel_hit;
	logic [N_IN-1:0] sel_lvl;
	logic [N_IN-1:0] wr_in;
	logic [N_OUT-1:0] wr_out;

	// ********************************
	// Write decode
	// ********************************
	wire wr_mode  = reg_wr && reg_addr == A_MODE;
	wire wr_setpt = reg_wr && reg_addr == A_SETPT;
	wire wr_uplim = reg_wr && reg_addr == A_UPLIM;
	wire wr_lolim = reg_wr && reg_addr == A_LOLIM;
	wire wr_swfrq = reg_wr && reg_addr == A_SWFRQ;
	wire wr_netin = reg_wr && reg_addr == A_NETIN;
	wire wr_irqst = reg_wr && reg_addr == A_IRQST;
	wire wr_msk   = reg_wr && reg_addr == A_IRQMSK;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg    <= RST_MODE;
			setpt_reg   <= PARAM_OFF;
			uplim_reg   <= PARAM_OFF;
			lolim_reg   <= PARAM_OFF;
			swfrq_reg   <= PARAM_OFF;
			netin_reg   <= '0;
			irq_msk_reg <= '0;
		end else begin
			if (wr_mode)  mode_reg <= reg_wdata[7:0];
			if (wr_setpt) setpt_reg <= reg_wdata;
			if (wr_uplim) uplim_reg <= reg_wdata;
			if (wr_lolim) lolim_reg <= reg_wdata;
			if (wr_swfrq) swfrq_reg <= reg_wdata;
			if (wr_netin) netin_reg <= reg_wdata[N_IN-1:0];
			if (wr_msk)   irq_msk_reg <= reg_wdata[N_EV-1:0];
		end
	end

	// ********************************
	// Terminal function tables
	// ********************************
	for (genvar i = 0; i < N_IN; i++) begin : g_in
		assign wr_in[i] = reg_wr && reg_addr == A_INFN0 + 8'(4 * i);
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				in_fn_reg[i] <= RST_INFN;
			end else if (wr_in[i]) begin
				in_fn_reg[i] <= reg_wdata[7:0];
			end
		end
		// Network bit counts the same as the pin
		assign sel_hit[i] = in_fn_reg[i] == IN_SEL;
		assign sel_lvl[i] = sel_hit[i] &
			(in_term[i] | netin_reg[i]);
	end
	for (genvar i = 0; i < N_OUT; i++) begin : g_out
		assign wr_out[i] = reg_wr && reg_addr == A_OUTFN0 + 8'(4 * i);
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				out_fn_reg[i] <= RST_OUTFN;
			end else if (wr_out[i]) begin
				out_fn_reg[i] <= reg_wdata[7:0];
			end
		end
	end

	// ********************************
	// Mode decode
	// ********************************
	wire mode_term = mode_reg == MODE_T_REV || mode_reg == MODE_T_FWD;
	wire mode_dev  = mode_reg == MODE_D_REV || mode_reg == MODE_D_FWD;
	wire mode_bus  = mode_reg == MODE_B_REV || mode_reg == MODE_B_FWD;
	wire mode_ok   = mode_term | mode_dev | mode_bus;
	wire lim_mode  = mode_term | mode_bus;
	wire sel_assigned = |sel_hit;
	wire sel_on       = |sel_lvl;
	// Unassigned select input leaves the mode alone in charge
	wire cfg_en = mode_ok && (!sel_assigned || sel_on);
	wire override = multi_speed | jog_cmd;
	// 9999 or anything above 400 Hz turns the start phase off
	wire sw_en = swfrq_reg <= SWFRQ_MAX;
	wire sw_reached = !sw_en || out_freq >= swfrq_reg;

	// ********************************
	// Switchover sequencing
	// ********************************
	always_comb begin
		sw_next = sw_reg;
		case (sw_reg)
			SW_STOP: if (drive_run) sw_next = SW_NORMAL;
			SW_NORMAL: begin
				if (!drive_run) sw_next = SW_STOP;
				else if (sw_reached) sw_next = SW_LOOP;
			end
			// Falling frequency does not leave the loop
			SW_LOOP: if (!drive_run) sw_next = SW_STOP;
			default: sw_next = SW_STOP;
		endcase
	end

	wire act_next = sw_reg == SW_LOOP && cfg_en && !override;

	// ********************************
	// Source selection
	// ********************************
	// Outside fieldbus mode the parameter wins over terminal 2 whenever it is set
	wire [DW-1:0] sp_term = setpt_reg == PARAM_OFF ?
		term2_value : setpt_reg;
	wire [DW-1:0] sp_sel  = mode_bus ? fb_set_value : sp_term;
	wire [DW-1:0] pv_sel  = mode_bus ?
		fb_meas_value : term4_value;
	wire [DW-1:0] dev_sel = mode_dev ?
		fb_deviation : sp_sel - pv_sel;

	// ********************************
	// Flags
	// ********************************
	wire up_next  = lim_mode && uplim_reg != PARAM_OFF &&
		pv_sel > uplim_reg;
	wire lo_next  = lim_mode && lolim_reg != PARAM_OFF &&
		pv_sel < lolim_reg;
	wire dir_next = drive_run && drive_fwd;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_reg           <= SW_STOP;
			loop_active_flag <= 1'b0;
			up_reg           <= 1'b0;
			lo_reg           <= 1'b0;
			dir_reg          <= 1'b0;
			sp_out           <= '0;
			pv_out           <= '0;
			dev_out          <= '0;
			dev_direct       <= 1'b0;
		end else begin
			sw_reg           <= sw_next;
			loop_active_flag <= act_next;
			up_reg           <= up_next;
			lo_reg           <= lo_next;
			dir_reg          <= dir_next;
			sp_out           <= sp_sel;
			pv_out           <= pv_sel;
			dev_out          <= dev_sel;
			dev_direct       <= mode_dev;
		end
	end

	// ********************************
	// Output terminals
	// ********************************
	pmf_flag_if flg ();
	assign flg.up  = up_reg;
	assign flg.lo  = lo_reg;
	assign flg.dir = dir_reg;
	assign flg.act = loop_active_flag;

	for (genvar i = 0; i < N_OUT; i++) begin : g_map
		pmf_out_map u_map (
			.clk      (clk),
			.rst      (rst),
			.code     (out_fn_reg[i]),
			.flags    (flg),
			.term_reg (out_term[i])
		);
	end

	// ********************************
	// Interrupts
	// ********************************
	assign ev[EV_LOOP] = act_next & ~loop_active_flag;
	assign ev[EV_SW]   = sw_next == SW_LOOP && sw_reg == SW_NORMAL;
	assign ev[EV_UP]   = up_next & ~up_reg;
	assign ev[EV_LO]   = lo_next & ~lo_reg;
	// A new event beats a write-one clear in the same cycle
	wire [N_EV-1:0] irq_st_next = (irq_st_reg &
		~(wr_irqst ? reg_wdata[N_EV-1:0] : '0)) | ev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_st_reg <= '0;
			irq        <= 1'b0;
		end else begin
			irq_st_reg <= irq_st_next;
			irq        <= |(irq_st_reg & irq_msk_reg);
		end
	end

	// ********************************
	// Read path
	// ********************************
	wire [AW-1:0] in_off  = reg_addr - A_INFN0;
	wire [AW-1:0] out_off = reg_addr - A_OUTFN0;
	wire in_hit  = reg_addr >= A_INFN0 && in_off < 8'(4 * N_IN) &&
		in_off[1:0] == 2'h0;
	wire out_hit = reg_addr >= A_OUTFN0 && out_off < 8'(4 * N_OUT) &&
		out_off[1:0] == 2'h0;
	wire [2:0] in_idx  = in_off[4:2];
	wire [1:0] out_idx = out_off[3:2];
	wire [DW-1:0] state_w = {6'h00, sel_on, sel_assigned, dir_reg,
		lo_reg, up_reg, loop_active_flag, 1'b0, sw_reg};

	wire [DW-1:0] rd_mux =
		reg_addr == A_MODE   ? {8'h00, mode_reg} :
		reg_addr == A_SETPT  ? setpt_reg :
		reg_addr == A_UPLIM  ? uplim_reg :
		reg_addr == A_LOLIM  ? lolim_reg :
		reg_addr == A_SWFRQ  ? swfrq_reg :
		reg_addr == A_NETIN  ? {9'h000, netin_reg} :
		reg_addr == A_IRQST  ? {12'h000, irq_st_reg} :
		reg_addr == A_IRQMSK ? {12'h000, irq_msk_reg} :
		reg_addr == A_STATE  ? state_w :
		in_hit  ? {8'h00, in_fn_reg[in_idx]} :
		out_hit ? {8'h00, out_fn_reg[out_idx]} : 16'h0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	mode_gate_a: assert property (
		loop_active_flag |-> $past(mode_ok))
		else $error("loop active in a non-loop mode");
	sel_gate_a: assert property (
		sel_assigned && !sel_on |=> !loop_active_flag)
		else $error("loop active with select input off");
	mode_only_a: assert property (
		sw_reg == SW_LOOP && mode_ok && !sel_assigned && !override
		|=> loop_active_flag)
		else $error("mode alone did not enable loop");
	normal_op_a: assert property (
		mode_reg == MODE_NONE |=> !loop_active_flag)
		else $error("loop active in mode zero");
	net_sel_a: assert property (
		|(sel_hit & netin_reg) && sw_reg == SW_LOOP && mode_ok &&
		!override |=> loop_active_flag)
		else $error("network select bit ignored");
	sp_term2_a: assert property (
		mode_term && setpt_reg == PARAM_OFF |=> sp_out == $past(term2_value))
		else $error("set point not from terminal 2");
	sp_param_a: assert property (
		!mode_bus && setpt_reg != PARAM_OFF |=> sp_out == $past(setpt_reg))
		else $error("set point parameter not used");
	pv_term4_a: assert property (
		mode_term |=> pv_out == $past(term4_value))
		else $error("measured value not from terminal 4");
	dev_bus_a: assert property (
		mode_dev |=> dev_direct && dev_out == $past(fb_deviation))
		else $error("fieldbus deviation not used");
	bus_vals_a: assert property (
		mode_bus |=> sp_out == $past(fb_set_value) &&
		pv_out == $past(fb_meas_value))
		else $error("fieldbus values not used");
	upper_flag_a: assert property (
		up_reg |-> $past(lim_mode && uplim_reg != PARAM_OFF &&
		pv_sel > uplim_reg))
		else $error("upper flag without cause");
	lower_flag_a: assert property (
		lo_reg |-> $past(lim_mode && lolim_reg != PARAM_OFF &&
		pv_sel < lolim_reg))
		else $error("lower flag without cause");
	dir_flag_a: assert property (
		!drive_run || !drive_fwd |=> !dir_reg)
		else $error("direction flag high while stopped");
	act_flag_a: assert property (
		loop_active_flag |-> $past(sw_reg == SW_LOOP))
		else $error("loop flag outside loop state");
	start_hold_a: assert property (
		sw_reg == SW_NORMAL && drive_run && sw_en && out_freq < swfrq_reg
		|=> sw_reg == SW_NORMAL)
		else $error("switchover before frequency reached");
	loop_keep_a: assert property (
		sw_reg == SW_LOOP && drive_run |=> sw_reg == SW_LOOP)
		else $error("loop left while running");
	override_a: assert property (
		override |=> !loop_active_flag)
		else $error("loop not suspended by jog or multi-speed");
	stop_clear_a: assert property (
		!drive_run |=> sw_reg == SW_STOP ##1 !loop_active_flag)
		else $error("switchover state kept after stop");

endmodule

// ### pmf_far.sv
// Far side model: process detector, set-point source and fieldbus host
`timescale 1ns/100ps
module pmf_far
	import pmf_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Commanded process state
	input  wire logic [DW-1:0] sp_cmd,
	input  wire logic [DW-1:0] pv_cmd,
	input  wire logic          fb_on,
	input  wire logic [DW-1:0] dev_cmd,
	input  wire logic [DW-1:0] set_cmd,
	input  wire logic [DW-1:0] meas_cmd,
	// Device side
	output logic      [DW-1:0] term2_value,
	output logic      [DW-1:0] term4_value,
	output logic      [DW-1:0] fb_deviation,
	output logic      [DW-1:0] fb_set_value,
	output logic      [DW-1:0] fb_meas_value
);
	logic [DW-1:0] churn_reg;

	// Analog terminals settle one cycle after a change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			churn_reg   <= 16'h5A5A;
			term2_value <= 16'h0000;
			term4_value <= 16'h0000;
		end else begin
			churn_reg   <= churn_reg + 16'h1357;
			term2_value <= sp_cmd;
			term4_value <= pv_cmd;
		end
	end

	// Host off the bus: words churn so stale data cannot pass as valid
	assign fb_deviation  = fb_on ? dev_cmd : churn_reg;
	assign fb_set_value  = fb_on ? set_cmd : ~churn_reg;
	assign fb_meas_value = fb_on ? meas_cmd : churn_reg ^ 16'h00FF;
endmodule

// ### tb.sv
// Testbench: loop mode block exercised through its register port
`timescale 1ns/100ps
module tb
	import pmf_pkg::*;
;
	logic             clk, rst, reg_wr, reg_rd, loop_active_flag, irq;
	logic [AW-1:0]    reg_addr;
	logic [DW-1:0]    reg_wdata, reg_rdata, out_freq, sp_out, pv_out, dev_out;
	logic [DW-1:0]    term2_value, term4_value;
	logic [DW-1:0]    fb_deviation, fb_set_value, fb_meas_value;
	logic [DW-1:0]    sp_cmd, pv_cmd, dev_cmd, set_cmd, meas_cmd;
	logic [N_IN-1:0]  in_term;
	logic [N_OUT-1:0] out_term;
	logic             drive_run, drive_fwd, multi_speed, jog_cmd;
	logic             dev_direct, fb_on;
	int               failures = 0;
	int               checks = 0;
	logic [7:0]       modes [0:7] = '{MODE_NONE, MODE_T_REV, MODE_T_FWD,
		MODE_D_REV, MODE_D_FWD, MODE_B_REV, MODE_B_FWD, 8'h16};
	logic [7:0]       act_exp = 8'h7E;

	pmf_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_term(in_term), .drive_run(drive_run),
		.drive_fwd(drive_fwd), .multi_speed(multi_speed), .jog_cmd(jog_cmd),
		.out_freq(out_freq), .term2_value(term2_value),
		.term4_value(term4_value), .fb_deviation(fb_deviation),
		.fb_set_value(fb_set_value), .fb_meas_value(fb_meas_value),
		.loop_active_flag(loop_active_flag), .sp_out(sp_out),
		.pv_out(pv_out), .dev_out(dev_out), .dev_direct(dev_direct),
		.out_term(out_term), .irq(irq));

	pmf_far far (.clk(clk), .rst(rst), .sp_cmd(sp_cmd), .pv_cmd(pv_cmd),
		.fb_on(fb_on), .dev_cmd(dev_cmd), .set_cmd(set_cmd),
		.meas_cmd(meas_cmd), .term2_value(term2_value),
		.term4_value(term4_value), .fb_deviation(fb_deviation),
		.fb_set_value(fb_set_value), .fb_meas_value(fb_meas_value));

	// ********************************
	// Helpers
	// ********************************
	task automatic end_of_test;
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic flag(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask

	// Covers detector lag, flag flop and mapper flop with margin
	task automatic settle;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	// ********************************
	// Clock, reset and watchdog
	// ********************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		end_of_test();
	end

	// ********************************
	// Tests
	// ********************************
	initial begin
		{rst, reg_wr, reg_rd, drive_run, drive_fwd} = 5'b10000;
		{multi_speed, jog_cmd, fb_on} = 3'b000;
		{reg_addr, reg_wdata, in_term, out_freq} = '0;
		{sp_cmd, pv_cmd, dev_cmd, set_cmd, meas_cmd} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(A_MODE, 16'h0000);
		rd(A_SETPT, PARAM_OFF);
		rd(A_UPLIM, PARAM_OFF);
		rd(A_LOLIM, PARAM_OFF);
		rd(A_SWFRQ, PARAM_OFF);
		rd(A_STATE, 16'h0001);
		wr(8'h24, 16'hFFFF);
		rd(8'h24, 16'h0000);
		// Mode table with running drive and no start phase
		wr(A_OUTFN0 + 8'h08, 16'h002F);
		@(posedge clk);
		drive_run <= 1'b1;
		drive_fwd <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(A_MODE, {8'h00, modes[i]});
			settle();
			flag(loop_active_flag, act_exp[i]);
			flag(out_term[2], act_exp[i]);
		end
		// Select input on terminal 2, then via network bit
		wr(A_MODE, 16'h0014);
		wr(A_INFN0 + 8'h08, {8'h00, IN_SEL});
		settle();
		flag(loop_active_flag, 1'b0);
		@(posedge clk);
		in_term <= 7'h04;
		settle();
		flag(loop_active_flag, 1'b1);
		@(posedge clk);
		in_term <= 7'h00;
		wr(A_NETIN, 16'h0004);
		settle();
		flag(loop_active_flag, 1'b1);
		wr(A_NETIN, 16'h0000);
		settle();
		flag(loop_active_flag, 1'b0);
		wr(A_INFN0 + 8'h08, 16'h0000);
		settle();
		flag(loop_active_flag, 1'b1);
		@(posedge clk);
		multi_speed <= 1'b1;
		settle();
		flag(loop_active_flag, 1'b0);
		@(posedge clk);
		multi_speed <= 1'b0;
		jog_cmd     <= 1'b1;
		settle();
		flag(loop_active_flag, 1'b0);
		@(posedge clk);
		jog_cmd <= 1'b0;
		// Source selection per mode
		@(posedge clk);
		sp_cmd   <= 16'h0190;
		pv_cmd   <= 16'h012C;
		fb_on    <= 1'b1;
		dev_cmd  <= 16'hFF38;
		set_cmd  <= 16'h0320;
		meas_cmd <= 16'h0258;
		settle();
		chk(sp_out, 16'h0190);
		chk(pv_out, 16'h012C);
		wr(A_SETPT, 16'h01F4);
		settle();
		chk(sp_out, 16'h01F4);
		wr(A_MODE, {8'h00, MODE_D_FWD});
		settle();
		chk(dev_out, 16'hFF38);
		flag(dev_direct, 1'b1);
		wr(A_MODE, {8'h00, MODE_B_REV});
		settle();
		chk(sp_out, 16'h0320);
		chk(pv_out, 16'h0258);
		// Limit and direction flags on terminals, two inverted
		wr(A_MODE, 16'h0014);
		wr(A_OUTFN0, {8'h00, OUT_UP});
		wr(A_OUTFN0 + 8'h04, 16'h0072);
		wr(A_OUTFN0 + 8'h08, 16'h0074);
		wr(A_UPLIM, 16'h0258);
		wr(A_LOLIM, 16'h00C8);
		@(posedge clk);
		pv_cmd <= 16'h02BC;
		settle();
		chk({13'h0000, out_term}, 16'h0003);
		wr(A_MODE, {8'h00, MODE_D_FWD});
		settle();
		chk({13'h0000, out_term}, 16'h0002);
		wr(A_MODE, 16'h0014);
		@(posedge clk);
		pv_cmd <= 16'h0064;
		settle();
		chk({13'h0000, out_term}, 16'h0000);
		rd(A_IRQST, 16'h000F);
		@(posedge clk);
		pv_cmd    <= 16'h0258;
		drive_fwd <= 1'b0;
		settle();
		chk({13'h0000, out_term}, 16'h0006);
		wr(A_UPLIM, PARAM_OFF);
		wr(A_LOLIM, PARAM_OFF);
		wr(A_OUTFN0 + 8'h04, 16'h0093);
		@(posedge clk);
		pv_cmd <= 16'h02BC;
		settle();
		chk({13'h0000, out_term}, 16'h0004);
		// Start phase until switchover frequency
		@(posedge clk);
		drive_run <= 1'b0;
		wr(A_SWFRQ, 16'h01F4);
		@(posedge clk);
		out_freq  <= 16'h0064;
		drive_run <= 1'b1;
		settle();
		flag(loop_active_flag, 1'b0);
		rd(A_STATE, 16'h0002);
		@(posedge clk);
		out_freq <= 16'h01F4;
		settle();
		rd(A_STATE, 16'h0014);
		@(posedge clk);
		out_freq <= 16'h0064;
		settle();
		flag(loop_active_flag, 1'b1);
		@(posedge clk);
		drive_run <= 1'b0;
		settle();
		rd(A_STATE, 16'h0001);
		wr(A_SWFRQ, SWFRQ_MAX);
		@(posedge clk);
		out_freq  <= 16'h0F9F;
		drive_run <= 1'b1;
		settle();
		flag(loop_active_flag, 1'b0);
		wr(A_SWFRQ, 16'h0FA1);
		settle();
		flag(loop_active_flag, 1'b1);
		// Interrupt: raise, mask, clear
		@(posedge clk);
		drive_run <= 1'b0;
		wr(A_SWFRQ, 16'h0000);
		wr(A_IRQST, 16'h000F);
		wr(A_IRQMSK, 16'h0001);
		settle();
		flag(irq, 1'b0);
		@(posedge clk);
		drive_run <= 1'b1;
		settle();
		flag(irq, 1'b1);
		rd(A_IRQST, 16'h0003);
		wr(A_IRQMSK, 16'h0000);
		settle();
		flag(irq, 1'b0);
		wr(A_IRQMSK, 16'h0001);
		wr(A_IRQST, 16'h0001);
		settle();
		flag(irq, 1'b0);
		rd(A_IRQST, 16'h0002);
		end_of_test();
	end
endmodule
